//--- stop_pf_sequencer.sv
`timescale 1ns/10ps
`include "stop_pf_params.svh"
// How it works
// - stop entry above the reset level turns regulator and crystal off, halts the cpu, keeps sram.
// - a supply dip shorter than the qualify time changes nothing and stop stays.
// - monitor on in stop and a warning-level supply: power up, warm up, leave stop.
// - supply between power-on and reset levels: cpu reset, power off, sram kept, monitor periodic.
// - supply below power-on level: held in reset with everything off.
// - monitor disabled in stop: drops that stay above the power-on level go unseen, no warning and no reset.
// - a wake interrupt with the monitor disabled turns it on; a warning level sets the flag.
// - waking from stop powers regulator and crystal and finishes warmup before the cpu runs.
// - after such a wake the cpu is told whether the power-fail interrupt goes first.
// - a wake check that finds the supply below the reset level resets the cpu and re-checks.
// - a re-check watches three ring ticks; if clean, release after warmup from 8000h.
// - the stop monitor disable bit resets to one.
// - re-check interval is continuous or one of three ring-tick lengths.
module stop_pf_sequencer
    import stop_pf_pkg::*;
#(
    parameter count_t WARMUP_CYCLES = count_t'(`WARMUP_CYC)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic        ring_osc_i,
    input  wire supply_s     supply_i,
    input  wire logic        stop_entry_i,
    input  wire logic        wake_irq_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output power_s           power_o,
    output logic             supply_warning_flag_o,
    output logic             service_pf_first_o,
    output logic             boot_start_o,
    output logic      [15:0] boot_addr_o,
    output logic             irq_o
);
    localparam logic [2:0] QUAL_MAX = 3'(`QUAL_CYC - 1);
    localparam logic [2:0] QUAL_END = 3'(`QUAL_CYC);
    localparam logic [2:0] TICK_END = 3'(`CHECK_TICKS - 1);

    seq_state_e state_reg;
    seq_state_e state_next;
    logic [3:0] sync_lvl;
    supply_s    q_lvl;
    logic [2:0] qual_cnt [3];
    logic       ring_d_reg;
    logic [2:0] chk_cnt_reg;
    logic [3:0] ctrl_reg;
    logic [3:0] status_reg;
    logic [3:0] mask_reg;
    logic       wr_pend_reg;
    logic [7:0] wr_ofs_reg;
    logic [3:0] set_vec;
    logic       boot_next;

    // address match shared by read and write decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    // re-check interval from the select field
    function automatic count_t interval_len(input logic [1:0] sel);
        unique case (sel)
            2'b00: return `INTERVAL_CONT;
            2'b01: return `INTERVAL_1;
            2'b10: return `INTERVAL_2;
            2'b11: return `INTERVAL_3;
        endcase
    endfunction

    // power outputs per state {reg, xtal, mon, rst, halt, retain}
    function automatic power_s pwr_of(input seq_state_e s, input logic mon);
        unique case (s)
            ST_POR_HOLD:   return 6'b000110;
            ST_RUN:        return 6'b111000;
            ST_STOP:       return {2'b00, mon, 3'b011};
            ST_WAKE_CHECK: return 6'b111011;
            ST_WARMUP:     return 6'b111011;
            ST_PF_RESET:   return 6'b000111;
            ST_PF_CHECK:   return 6'b001111;
            ST_PF_WARMUP:  return 6'b111111;
        endcase
    endfunction

    // comparators and ring clock come from outside the clock domain
    pin_sync3 u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .d_i     ({supply_i, ring_osc_i}),
        .q_o     (sync_lvl)
    );

    // qualified supply levels: a change must persist to count
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q_lvl <= 3'b000;
            for (int i = 0; i < 3; i++) qual_cnt[i] <= 3'b000;
        end else if (ce_i) begin
            for (int i = 0; i < 3; i++) begin
                if (sync_lvl[i+1] == q_lvl[i]) begin
                    qual_cnt[i] <= 3'b000;
                end else if (qual_cnt[i] == QUAL_MAX) begin
                    q_lvl[i]    <= sync_lvl[i+1];
                    qual_cnt[i] <= 3'b000;
                end else begin
                    qual_cnt[i] <= qual_cnt[i] + 3'b001;
                end
            end
        end
    end

    // supply classes and ring-tick edge
    wire ring_tick = sync_lvl[0] & ~ring_d_reg;
    wire below_por = ~q_lvl.above_por;
    wire below_rst = q_lvl.above_por & ~q_lvl.above_rst;
    wire warn_lvl  = q_lvl.above_rst & ~q_lvl.above_pfw;
    wire mon_dis   = ctrl_reg[`CTRL_DIS_BIT];
    wire mon_stop  = ~mon_dis;
    wire entering  = (state_next != state_reg);
    wire warm_done;
    wire intv_done;
    wire wake_done = (chk_cnt_reg == QUAL_END);
    wire pf_done   = ring_tick & (chk_cnt_reg == TICK_END);

    // warmup counter in clock cycles
    down_timer u_warm (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .load_i     (entering && (state_next == ST_WARMUP ||
                                  state_next == ST_PF_WARMUP)),
        .load_val_i (WARMUP_CYCLES),
        .tick_i     (1'b1),
        .done_o     (warm_done)
    );

    // re-check interval in ring ticks
    down_timer u_intv (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .load_i     (entering && state_next == ST_PF_RESET),
        .load_val_i (interval_len(ctrl_reg[`CTRL_SEL_HI:`CTRL_SEL_LO])),
        .tick_i     (ring_tick),
        .done_o     (intv_done)
    );

    // sequencer next state and event sets
    always_comb begin
        state_next = state_reg;
        set_vec    = 4'h0;
        boot_next  = 1'b0;
        if (below_por) begin
            state_next = ST_POR_HOLD;
            if (state_reg != ST_POR_HOLD) set_vec[`ST_POR_BIT] = 1'b1;
        end else begin
            unique case (state_reg)
                ST_POR_HOLD: begin
                    state_next = below_rst ? ST_PF_RESET : ST_PF_WARMUP;
                end
                ST_RUN: begin
                    if (below_rst) begin
                        state_next = ST_PF_RESET;
                        set_vec[`ST_PFRST_BIT] = 1'b1;
                    end else if (stop_entry_i) begin
                        state_next = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (mon_stop && below_rst) begin
                        state_next = ST_PF_RESET;
                        set_vec[`ST_PFRST_BIT] = 1'b1;
                    end else if (mon_stop && warn_lvl) begin
                        state_next = ST_WARMUP;
                        set_vec[`ST_WARN_BIT] = 1'b1;
                    end else if (wake_irq_i) begin
                        state_next = mon_dis ? ST_WAKE_CHECK : ST_WARMUP;
                    end
                end
                ST_WAKE_CHECK: begin
                    if (wake_done && below_rst) begin
                        state_next = ST_PF_RESET;
                        set_vec[`ST_PFRST_BIT] = 1'b1;
                    end else if (wake_done) begin
                        state_next = ST_WARMUP;
                        set_vec[`ST_WARN_BIT] = warn_lvl;
                    end
                end
                ST_WARMUP: begin
                    if (warm_done) begin
                        state_next = ST_RUN;
                        set_vec[`ST_WAKE_BIT] = 1'b1;
                    end
                end
                ST_PF_RESET: begin
                    if (intv_done) state_next = ST_PF_CHECK;
                end
                ST_PF_CHECK: begin
                    if (below_rst) begin
                        state_next = ST_PF_RESET;
                    end else if (pf_done) begin
                        state_next = ST_PF_WARMUP;
                    end
                end
                ST_PF_WARMUP: begin
                    if (below_rst) begin
                        state_next = ST_PF_RESET;
                    end else if (warm_done) begin
                        state_next = ST_RUN;
                        boot_next  = 1'b1;
                    end
                end
            endcase
        end
    end

    // state, check counter and power outputs
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg   <= ST_POR_HOLD;
            ring_d_reg  <= 1'b0;
            chk_cnt_reg <= 3'b000;
            power_o     <= 6'b000110;
        end else if (ce_i) begin
            state_reg   <= state_next;
            ring_d_reg  <= sync_lvl[0];
            power_o     <= pwr_of(state_next, mon_stop);
            if (entering) begin
                chk_cnt_reg <= 3'b000;
            end else if (state_reg == ST_WAKE_CHECK ||
                         (state_reg == ST_PF_CHECK && ring_tick)) begin
                chk_cnt_reg <= chk_cnt_reg + 3'b001;
            end
        end
    end

    // bus decode: address phase taken, write lands in data phase
    wire        ahb_go   = hsel_i & hready_i & htrans_i[1];
    wire [7:0]  a_ofs    = haddr_i[7:0];
    wire        wr_ctrl  = wr_pend_reg & hit(wr_ofs_reg, `OFS_CTRL);
    wire        wr_stat  = wr_pend_reg & hit(wr_ofs_reg, `OFS_STATUS);
    wire        wr_mask  = wr_pend_reg & hit(wr_ofs_reg, `OFS_MASK);
    wire [3:0]  clr_vec  = wr_stat ? hwdata_i[3:0] : 4'h0;
    wire [3:0]  stat_nxt = (status_reg & ~clr_vec) | set_vec;
    wire [31:0] rd_word  =
        hit(a_ofs, `OFS_CTRL)   ? {28'h000_0000, ctrl_reg}   :
        hit(a_ofs, `OFS_STATUS) ? {28'h000_0000, status_reg} :
        hit(a_ofs, `OFS_MASK)   ? {28'h000_0000, mask_reg}   :
        hit(a_ofs, `OFS_STATE)  ? {24'h00_0000, 1'b0, q_lvl,
                                   1'b0, state_reg}           :
        32'h0000_0000;

    // bus slave, never waits, always okay
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_pend_reg <= 1'b0;
            wr_ofs_reg  <= 8'h00;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b0;
            hresp_o     <= 1'b0;
        end else if (ce_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            wr_pend_reg <= ahb_go & hwrite_i;
            wr_ofs_reg  <= a_ofs;
            if (ahb_go && !hwrite_i) hrdata_o <= rd_word;
        end
    end

    // registers, sticky status with set over clear, interrupt
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_reg              <= `CTRL_RESET;
            status_reg            <= `STATUS_RESET;
            mask_reg              <= `MASK_RESET;
            irq_o                 <= 1'b0;
            supply_warning_flag_o <= 1'b0;
            service_pf_first_o    <= 1'b0;
            boot_start_o          <= 1'b0;
            boot_addr_o           <= `BOOT_ADDR;
        end else if (ce_i) begin
            if (wr_ctrl) ctrl_reg <= hwdata_i[3:0];
            if (wr_mask) mask_reg <= hwdata_i[3:0];
            status_reg            <= stat_nxt;
            irq_o                 <= |(stat_nxt & mask_reg);
            supply_warning_flag_o <= stat_nxt[`ST_WARN_BIT];
            service_pf_first_o    <= stat_nxt[`ST_WARN_BIT] &
                                     ctrl_reg[`CTRL_PRIO_BIT];
            boot_start_o          <= boot_next;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_wake_blind;
        ce_i && state_reg == ST_STOP && mon_dis && wake_irq_i && !below_por;
    endsequence
    sequence s_check_on;
        state_reg == ST_WAKE_CHECK && power_o.monitor_en &&
        power_o.regulator_en && power_o.crystal_en;
    endsequence

    a_stop_power_off: assert property (state_reg == ST_STOP |->
        !power_o.regulator_en && !power_o.crystal_en &&
        power_o.cpu_halt && power_o.sram_retain)
        else $error("stop mode with power on");
    a_dip_ignored: assert property (ce_i && state_reg == ST_STOP &&
        !wake_irq_i && q_lvl == 3'b111 |=> state_reg == ST_STOP)
        else $error("stop left without cause");
    a_warn_wakes: assert property (ce_i && state_reg == ST_STOP &&
        mon_stop && warn_lvl |=> state_reg == ST_WARMUP &&
        status_reg[`ST_WARN_BIT])
        else $error("warning in stop not acted on");
    a_pf_reset_hold: assert property (state_reg == ST_PF_RESET |->
        power_o.cpu_reset && !power_o.regulator_en &&
        !power_o.monitor_en && power_o.sram_retain)
        else $error("power-fail reset outputs wrong");
    a_por_hold: assert property (ce_i && below_por |=>
        state_reg == ST_POR_HOLD ##0 power_o == 6'b000110)
        else $error("below power-on not held");
    a_blind_stop: assert property (ce_i && state_reg == ST_STOP &&
        mon_dis && !wake_irq_i && !below_por |=> state_reg == ST_STOP)
        else $error("disabled monitor reacted");
    a_wake_check: assert property (s_wake_blind |=> s_check_on)
        else $error("wake did not start a supply check");
    a_warm_first: assert property (state_reg == ST_WARMUP &&
        !warm_done |=> state_reg != ST_RUN)
        else $error("cpu released before warmup");
    a_check_ticks: assert property (state_reg == ST_PF_CHECK &&
        state_next == ST_PF_WARMUP |-> chk_cnt_reg == TICK_END &&
        ring_tick && !below_rst)
        else $error("re-check released early");
    a_irq_level: assert property (ce_i |=>
        irq_o == |($past(stat_nxt) & $past(mask_reg)))
        else $error("interrupt level wrong");
endmodule

//--- stop_pf_params.svh
`ifndef STOP_PF_PARAMS_SVH
`define STOP_PF_PARAMS_SVH

// clock and timing
`define CLK_PERIOD_NS   20
`define QUAL_TIME_NS    100
`define QUAL_CYC        ((`QUAL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WARMUP_TIME_NS  200000
`define WARMUP_CYC  ((`WARMUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHECK_TICKS     3

// re-check intervals in ring ticks
`define INTERVAL_CONT   14'h0001
`define INTERVAL_1      14'h0800
`define INTERVAL_2      14'h1000
`define INTERVAL_3      14'h2000

// restart address after a power-fail reset
`define BOOT_ADDR       16'h8000

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_MASK        8'h08
`define OFS_STATE       8'h0C

// control fields and reset value
`define CTRL_DIS_BIT    0
`define CTRL_SEL_LO     1
`define CTRL_SEL_HI     2
`define CTRL_PRIO_BIT   3
`define CTRL_RESET      4'h1

// status fields and reset values
`define ST_WARN_BIT     0
`define ST_PFRST_BIT    1
`define ST_WAKE_BIT     2
`define ST_POR_BIT      3
`define STATUS_RESET    4'h0
`define MASK_RESET      4'h0

`endif

//--- stop_pf_pkg.sv
package stop_pf_pkg;

    typedef enum logic [2:0] {
        ST_POR_HOLD   = 3'b000,
        ST_RUN        = 3'b001,
        ST_STOP       = 3'b010,
        ST_WAKE_CHECK = 3'b011,
        ST_WARMUP     = 3'b100,
        ST_PF_RESET   = 3'b101,
        ST_PF_CHECK   = 3'b110,
        ST_PF_WARMUP  = 3'b111
    } seq_state_e;

    typedef struct packed {
        logic above_pfw;
        logic above_rst;
        logic above_por;
    } supply_s;

    typedef struct packed {
        logic regulator_en;
        logic crystal_en;
        logic monitor_en;
        logic cpu_reset;
        logic cpu_halt;
        logic sram_retain;
    } power_s;

    typedef logic [13:0] count_t;

endpackage

//--- pin_sync3.sv
`timescale 1ns/10ps
module pin_sync3 (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [3:0] d_i,
    output logic      [3:0] q_o
);
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] q_next;

    // take a new level only where stages two and three agree
    assign q_next = ((s2_reg ~^ s3_reg) & s2_reg) | ((s2_reg ^ s3_reg) & q_o);

    // three-stage pipe, first stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 4'h0;
            s2_reg <= 4'h0;
            s3_reg <= 4'h0;
            q_o    <= 4'h0;
        end else if (ce_i) begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_o    <= q_next;
        end
    end
endmodule

//--- down_timer.sv
`timescale 1ns/10ps
module down_timer
    import stop_pf_pkg::*;
(
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    input  wire logic   ce_i,
    input  wire logic   load_i,
    input  wire count_t load_val_i,
    input  wire logic   tick_i,
    output logic        done_o
);
    count_t cnt_reg;

    // load wins, then count down to zero and rest there
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 14'h0000;
        end else if (ce_i) begin
            if (load_i) begin
                cnt_reg <= load_val_i;
            end else if (tick_i && cnt_reg != 14'h0000) begin
                cnt_reg <= cnt_reg - 14'h0001;
            end
        end
    end

    assign done_o = (cnt_reg == 14'h0000);
endmodule

//--- supply_model.sv
`timescale 1ns/10ps
module supply_model
    import stop_pf_pkg::*;
(
    input  wire logic [1:0] level_i,
    output logic            ring_osc_o,
    output supply_s         supply_o
);
    // free running ring clock, sped up, off phase to clk
    initial ring_osc_o = 1'b0;
    always #41 ring_osc_o = ~ring_osc_o;

    // comparator ladder: 0 below por, 1 below rst, 2 warn, 3 good
    assign supply_o.above_por = (level_i >= 2'h1);
    assign supply_o.above_rst = (level_i >= 2'h2);
    assign supply_o.above_pfw = (level_i == 2'h3);
endmodule

//--- stop_mode_power_fail_sequencer_test.sv
`timescale 1ns/10ps
`include "stop_pf_params.svh"
module stop_mode_power_fail_sequencer_test;
    import stop_pf_pkg::*;
    localparam count_t WARM = 14'h0008;
    logic        clk_i   = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        stop_rq = 1'b0;
    logic        wake_rq = 1'b0;
    logic        hsel    = 1'b0;
    logic        hwrite  = 1'b0;
    logic [1:0]  level   = 2'h3;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0000_0000;
    logic [31:0] hwdata  = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hready;
    logic        hresp;
    logic        ring;
    supply_s     supply;
    power_s      power;
    logic        flag;
    logic        pf_first;
    logic        boot;
    logic [15:0] boot_addr;
    logic        irq;
    wire  [7:0]  obs;
    int          fails = 0;
    int          samples_checked = 0;
    int          c;

    assign obs = {boot, flag, power};
    always #10 clk_i = ~clk_i;

    supply_model far (.level_i(level), .ring_osc_o(ring), .supply_o(supply));
    stop_pf_sequencer #(.WARMUP_CYCLES(WARM)) dut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .ring_osc_i(ring),
        .supply_i(supply), .stop_entry_i(stop_rq), .wake_irq_i(wake_rq),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .power_o(power), .supply_warning_flag_o(flag),
        .service_pf_first_o(pf_first), .boot_start_o(boot),
        .boot_addr_o(boot_addr), .irq_o(irq));

    task complete_run;
        $display("checks %0d fails %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, g);
        end
    endtask

    task stall(input string s);
        fails++;
        $display("CHECK FAILED %s expected done seen timeout", s);
        complete_run;
    endtask

    // wait on masked outputs, cycles left in c
    task wobs(input logic [7:0] m, input logic [7:0] v, input int lim);
        c = 0;
        while ((obs & m) !== v && c < lim) begin
            @(posedge clk_i);
            c++;
        end
        if ((obs & m) !== v)
            stall("outputs");
    endtask

    task rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1)
            stall("hready");
    endtask

    // one single word transfer, read data left in rd
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h00_0000, a};
        rdy;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        rdy;
        rd = hrdata;
        chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
    endtask

    task rstate(input logic [2:0] e);
        bus(1'b0, `OFS_STATE, 32'h0000_0000);
        chk("state", {29'h0, e}, {29'h0, rd[2:0]});
    endtask

    task req(input logic w);
        @(posedge clk_i);
        stop_rq <= ~w;
        wake_rq <= w;
        @(posedge clk_i);
        stop_rq <= 1'b0;
        wake_rq <= 1'b0;
    endtask

    task t_reset;
        chk("power in reset", 32'h0000_0006, 32'(power));
        @(posedge clk_i);
        rst_n_i <= 1'b1;
        wobs(8'h80, 8'h80, 400);
        chk("boot addr", 32'h0000_8000, {16'h0000, boot_addr});
        bus(1'b0, `OFS_CTRL, 32'h0000_0000);
        chk("ctrl reset", 32'h0000_0001, rd);
        bus(1'b0, `OFS_MASK, 32'h0000_0000);
        chk("mask reset", 32'h0000_0000, rd);
        bus(1'b1, 8'h10, 32'h0000_000F);
        bus(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        bus(1'b1, `OFS_STATUS, 32'h0000_000F);
        rstate(3'h1);
        $display("test reset done");
    endtask

    task t_stop_dis;
        bus(1'b1, `OFS_CTRL, 32'h0000_0009);
        req(1'b0);
        wobs(8'h3F, 8'h03, 50);
        @(posedge clk_i) level <= 2'h1;
        repeat (40) @(posedge clk_i);
        rstate(3'h2);
        chk("flag in stop", 32'h0000_0000, 32'(flag));
        @(posedge clk_i) level <= 2'h2;
        // let the new level qualify while the monitor is off
        repeat (20) @(posedge clk_i);
        req(1'b1);
        wobs(8'h3F, 8'h3B, 50);
        wobs(8'h02, 8'h00, 100);
        chk("warmup held", 32'h0000_0001, 32'(c >= WARM));
        chk("flag", 32'h0000_0001, 32'(flag));
        chk("pf first", 32'h0000_0001, 32'(pf_first));
        bus(1'b0, `OFS_STATUS, 32'h0000_0000);
        chk("status", 32'h0000_0005, rd);
        chk("irq masked", 32'h0000_0000, 32'(irq));
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        bus(1'b1, `OFS_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk_i);
        chk("pf last", 32'h0000_0000, 32'(pf_first));
        chk("irq", 32'h0000_0001, 32'(irq));
        @(posedge clk_i) level <= 2'h3;
        repeat (20) @(posedge clk_i);
        bus(1'b1, `OFS_STATUS, 32'h0000_0005);
        repeat (2) @(posedge clk_i);
        chk("irq cleared", 32'h0000_0000, 32'(irq));
        $display("test stop monitor off done");
    endtask

    task t_stop_mon;
        bus(1'b1, `OFS_CTRL, 32'h0000_0000);
        req(1'b0);
        wobs(8'h3F, 8'h0B, 50);
        @(posedge clk_i) level <= 2'h2;
        repeat (3) @(posedge clk_i);
        level <= 2'h3;
        repeat (20) @(posedge clk_i);
        rstate(3'h2);
        chk("flag after dip", 32'h0000_0000, 32'(flag));
        @(posedge clk_i) level <= 2'h2;
        wobs(8'h30, 8'h30, 50);
        wobs(8'h02, 8'h00, 100);
        chk("warmup held", 32'h0000_0001, 32'(c >= WARM));
        rstate(3'h1);
        chk("flag", 32'h0000_0001, 32'(flag));
        @(posedge clk_i) level <= 2'h3;
        repeat (20) @(posedge clk_i);
        bus(1'b1, `OFS_STATUS, 32'h0000_000F);
        $display("test stop monitor on done");
    endtask

    task t_pf;
        int t;
        bus(1'b1, `OFS_CTRL, 32'h0000_0003);
        req(1'b0);
        wobs(8'h3F, 8'h03, 50);
        @(posedge clk_i) level <= 2'h1;
        repeat (20) @(posedge clk_i);
        req(1'b1);
        wobs(8'h3F, 8'h07, 200);
        for (int s = 1; s < 4; s++) begin
            t = (2048 << (s - 1)) * 41 / 10;
            // next select lands while this interval runs
            bus(1'b1, `OFS_CTRL, 32'((s * 2 + 3) & 7));
            wobs(8'h08, 8'h08, 40000);
            chk("interval", 32'h0000_0001, 32'(c > t - 60 && c < t + 60));
        end
        bus(1'b1, `OFS_CTRL, 32'h0000_0001);
        @(posedge clk_i) level <= 2'h3;
        wobs(8'h80, 8'h80, 3000);
        chk("boot addr", 32'h0000_8000, {16'h0000, boot_addr});
        $display("test power fail done");
    endtask

    task t_por;
        @(posedge clk_i) level <= 2'h0;
        wobs(8'h3F, 8'h06, 100);
        rstate(3'h0);
        @(posedge clk_i) level <= 2'h3;
        wobs(8'h80, 8'h80, 500);
        $display("test power on done");
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        t_reset;
        t_stop_dis;
        t_stop_mon;
        t_pf;
        t_por;
        complete_run;
    end
endmodule
